// ### verilog/pulse_width_dac_control.sv
// What this block does
// - Limit quarter 256 cycles, half 256, full
// - Ramp disconnect switch on gradually
// - Pin high enables, starting with soft start
// - Pin low 560 us shuts down
// - Disconnect switch open while shut down
// - Output setting is 6-bit DAC code
// - Code zero gives highest output voltage
// - Start-up presets code to centre, 32
// - Low 1 to 60 us steps up
// - Low 140 to 240 us steps down
// - Undervoltage keeps both switches open
// - Overtemperature shuts down, switches open
// - Stay off 400 ns and until feedback low
// - On at feedback low, off at peak
`timescale 1ns/1ps
`default_nettype none
`include "link_timing_defs.svh"
module pulse_width_dac_control #(
    parameter logic [15:0] UP_MAX_CYC  = 16'(`UP_MAX_CYC),
    parameter logic [15:0] DN_MIN_CYC  = 16'(`DN_MIN_CYC),
    parameter logic [15:0] DN_MAX_CYC  = 16'(`DN_MAX_CYC),
    parameter logic [15:0] OFF_MIN_CYC = 16'(`OFF_MIN_CYC)
) (
    input  wire logic           clk_i,
    input  wire logic           sys_rst_i,
    ctrl_link_if.dev            link,
    input  wire logic           uvlo_i,
    input  wire logic           overtemp_i,
    input  wire logic           fb_below_ref_i,
    input  wire logic           peak_reached_i,
    output logic [3:0]          input_disconnect_switch_o,
    output logic                main_power_switch_o,
    output link_pkg::lim_t      switch_current_limit_o,
    output logic [5:0]          dac_code_o,
    output logic                enabled_o
);
    import link_pkg::*;

    localparam logic [15:0] UP_MIN_CYC  = 16'(`UP_MIN_CYC);
    localparam logic [9:0]  MAX_ON_CYC  = 10'(`MAX_ON_CYC);
    localparam logic [9:0]  MIN_OFF_CYC = 10'(`MIN_OFF_CYC);
    localparam logic [7:0]  SS_LAST     = 8'(`SS_STEP_CYCLES - 1);
    localparam logic [6:0]  RAMP_LAST   = 7'(`RAMP_STEP_CYC - 1);

    // Windows must be ordered or a pulse could mean two things
    if (UP_MIN_CYC > UP_MAX_CYC || UP_MAX_CYC >= DN_MIN_CYC ||
        DN_MIN_CYC > DN_MAX_CYC || DN_MAX_CYC >= OFF_MIN_CYC) begin : g_chk
        $error("pulse windows overlap or are out of order");
    end

    function automatic logic in_window(input logic [15:0] w,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
        in_window = (w >= lo) && (w <= hi);
    endfunction : in_window

    // Pin and comparator inputs are asynchronous: two flops each
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= {link.ctrl, uvlo_i, overtemp_i,
                        fb_below_ref_i, peak_reached_i};
            sync_ff <= meta_ff;
        end
    end

    wire ctrl_s = sync_ff[4];
    wire uvlo_s = sync_ff[3];
    wire otp_s  = sync_ff[2];
    wire fb_s   = sync_ff[1];
    wire peak_s = sync_ff[0];

    logic             ctrl_d_ff;
    logic [15:0]      low_cnt_ff;
    pwr_state_t       pwr_ff;
    logic [3:0]       gate_ff;
    logic [6:0]       ramp_cnt_ff;
    logic [5:0]       dac_ff;
    sw_state_t        sw_ff;
    logic [9:0]       sw_cnt_ff;
    lim_t             lim_ff;
    logic [7:0]       ss_cnt_ff;

    // Low-time measurement, saturating so a long low never wraps
    wire [15:0] nxt_low_cnt = ctrl_s ? 16'h0000 :
                 (low_cnt_ff == 16'hFFFF) ? low_cnt_ff : low_cnt_ff + 16'h0001;
    wire rise      = ctrl_s & ~ctrl_d_ff;
    // Width is judged at the rising edge; the high gap separates pulses
    wire step_up   = rise && in_window(low_cnt_ff, UP_MIN_CYC, UP_MAX_CYC);
    wire step_dn   = rise && in_window(low_cnt_ff, DN_MIN_CYC, DN_MAX_CYC);
    wire off_hit   = ~ctrl_s && (low_cnt_ff >= OFF_MIN_CYC);
    wire fault     = uvlo_s | otp_s;
    wire stop      = fault | off_hit;
    wire start     = ctrl_s & ~fault;
    wire ramp_tick = (ramp_cnt_ff == RAMP_LAST);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_d_ff  <= 1'b0;
            low_cnt_ff <= 16'h0000;
        end else begin
            ctrl_d_ff  <= ctrl_s;
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    // Power sequencing: off, gradual disconnect turn-on, run
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwr_ff      <= PWR_OFF;
            gate_ff     <= 4'h0;
            ramp_cnt_ff <= 7'h00;
        end else begin
            unique case (pwr_ff)
                PWR_OFF: begin
                    gate_ff     <= 4'h0;
                    ramp_cnt_ff <= 7'h00;
                    if (start) begin
                        pwr_ff <= PWR_RAMP;
                    end
                end
                PWR_RAMP: begin
                    ramp_cnt_ff <= ramp_tick ? 7'h00 : ramp_cnt_ff + 7'h01;
                    if (stop) begin
                        pwr_ff  <= PWR_OFF;
                        gate_ff <= 4'h0;
                    end else if (ramp_tick) begin
                        // Gate steps up slowly to hold down inrush
                        gate_ff <= gate_ff + 4'h1;
                        if (gate_ff == (`GATE_FULL - 4'h1)) begin
                            pwr_ff <= PWR_RUN;
                        end
                    end
                end
                PWR_RUN: begin
                    if (stop) begin
                        pwr_ff  <= PWR_OFF;
                        gate_ff <= 4'h0;
                    end
                end
            endcase
        end
    end

    // DAC code; a larger code means a lower converter output
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dac_ff <= `DAC_CENTER;
        end else if (pwr_ff == PWR_OFF) begin
            dac_ff <= `DAC_CENTER;
        end else if (step_up && dac_ff != `DAC_MAX) begin
            dac_ff <= dac_ff + 6'h01;
        end else if (step_dn && dac_ff != 6'h00) begin
            dac_ff <= dac_ff - 6'h01;
        end
    end

    // Main switch timing: on at feedback low, off at peak or max on
    wire run     = (pwr_ff == PWR_RUN) && !stop;
    wire on_end  = peak_s || (sw_cnt_ff == MAX_ON_CYC);
    wire rest_ok = (sw_cnt_ff >= MIN_OFF_CYC - 10'h001) && fb_s;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run) begin
            sw_ff     <= SW_IDLE;
            sw_cnt_ff <= 10'h000;
        end else begin
            unique case (sw_ff)
                SW_IDLE: begin
                    sw_cnt_ff <= 10'h000;
                    if (fb_s) begin
                        sw_ff <= SW_ON;
                    end
                end
                SW_ON: begin
                    if (on_end) begin
                        sw_ff     <= SW_REST;
                        sw_cnt_ff <= 10'h000;
                    end else begin
                        sw_cnt_ff <= sw_cnt_ff + 10'h001;
                    end
                end
                SW_REST: begin
                    if (rest_ok) begin
                        sw_ff     <= SW_ON;
                        sw_cnt_ff <= 10'h000;
                    end else if (sw_cnt_ff < MIN_OFF_CYC) begin
                        sw_cnt_ff <= sw_cnt_ff + 10'h001;
                    end
                end
            endcase
        end
    end

    // Soft start: count switch cycles, raise limit in two steps
    wire sw_done = (sw_ff == SW_ON) && on_end && run;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || pwr_ff == PWR_OFF) begin
            lim_ff    <= LIM_QUARTER;
            ss_cnt_ff <= 8'h00;
        end else if (sw_done && lim_ff != LIM_FULL) begin
            ss_cnt_ff <= ss_cnt_ff + 8'h01;
            if (ss_cnt_ff == SS_LAST) begin
                lim_ff <= (lim_ff == LIM_QUARTER) ? LIM_HALF : LIM_FULL;
            end
        end
    end

    // Outputs straight from flops; switch flop takes run and SW_ON, cleared by on_end
    logic main_sw_ff;
    logic enabled_ff;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_sw_ff <= 1'b0;
            enabled_ff <= 1'b0;
        end else begin
            main_sw_ff <= run && (sw_ff == SW_ON) && !on_end;
            enabled_ff <= (pwr_ff != PWR_OFF);
        end
    end

    assign input_disconnect_switch_o = gate_ff;
    assign main_power_switch_o       = main_sw_ff;
    assign switch_current_limit_o    = lim_ff;
    assign dac_code_o                = dac_ff;
    assign enabled_o                 = enabled_ff;
endmodule : pulse_width_dac_control
`default_nettype wire

// ### verilog/link_timing_defs.svh
`ifndef LINK_TIMING_DEFS_SVH
`define LINK_TIMING_DEFS_SVH

// Clock period of clk_i
`define CLK_PERIOD_NS 10

// Control pin pulse windows, in ns as specified
`define UP_MIN_NS     1000
`define UP_MAX_NS     60000
`define DN_MIN_NS     140000
`define DN_MAX_NS     240000
`define OFF_MIN_NS    560000
`define GAP_MIN_NS    1000

// Switching times, in ns
`define MAX_ON_NS     6000
`define MIN_OFF_NS    400

// Least times round up, longest times round down
`define UP_MIN_CYC  ((`UP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UP_MAX_CYC  (`UP_MAX_NS / `CLK_PERIOD_NS)
`define DN_MIN_CYC  ((`DN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DN_MAX_CYC  (`DN_MAX_NS / `CLK_PERIOD_NS)
`define OFF_MIN_CYC ((`OFF_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_MIN_CYC ((`GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_ON_CYC  (`MAX_ON_NS / `CLK_PERIOD_NS)
`define MIN_OFF_CYC ((`MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host pulse targets, centred in the windows
`define HOST_UP_NS    30000
`define HOST_DN_NS    190000
`define HOST_GAP_NS   2000
`define HOST_UP_CYC   (`HOST_UP_NS / `CLK_PERIOD_NS)
`define HOST_DN_CYC   (`HOST_DN_NS / `CLK_PERIOD_NS)
`define HOST_GAP_CYC  (`HOST_GAP_NS / `CLK_PERIOD_NS)

// Soft start and disconnect ramp
`define SS_STEP_CYCLES 256
`define RAMP_STEP_CYC  100
`define DAC_CENTER     6'h20
`define DAC_MAX        6'h3F
`define GATE_FULL      4'hF

`endif

// ### verilog/link_pkg.sv
package link_pkg;
    typedef enum logic [1:0] {
        LIM_QUARTER,
        LIM_HALF,
        LIM_FULL
    } lim_t;
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_RAMP,
        PWR_RUN
    } pwr_state_t;
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_ON,
        SW_REST
    } sw_state_t;
    typedef enum logic [1:0] {
        HOST_HIGH,
        HOST_PULSE,
        HOST_GAP
    } host_state_t;
endpackage : link_pkg

// ### verilog/ctrl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// One push-pull control wire from host to converter
interface ctrl_link_if;
    logic ctrl;
    modport host (output ctrl);
    modport dev  (input  ctrl);
endinterface : ctrl_link_if
`default_nettype wire

// ### verilog/ctrl_pin_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_timing_defs.svh"
module ctrl_pin_host #(
    parameter logic [15:0] UP_CYC  = 16'(`HOST_UP_CYC),
    parameter logic [15:0] DN_CYC  = 16'(`HOST_DN_CYC),
    parameter logic [15:0] GAP_CYC = 16'(`HOST_GAP_CYC)
) (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    ctrl_link_if.host  link,
    input  wire logic  enable_i,
    input  wire logic  step_up_i,
    input  wire logic  step_down_i,
    output logic       busy_o
);
    import link_pkg::*;

    if (UP_CYC == 16'h0000 || DN_CYC <= UP_CYC ||
        GAP_CYC < 16'(`GAP_MIN_CYC)) begin : g_chk
        $error("host pulse lengths unusable");
    end

    host_state_t st_ff;
    logic [15:0] cnt_ff;
    logic        ctrl_ff;
    logic        busy_ff;

    wire done = (cnt_ff == 16'h0001);

    // Pin low whenever disabled; while enabled, low only for a pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !enable_i) begin
            st_ff   <= HOST_HIGH;
            cnt_ff  <= 16'h0000;
            ctrl_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                HOST_HIGH: begin
                    ctrl_ff <= 1'b1;
                    if (step_up_i || step_down_i) begin
                        st_ff   <= HOST_PULSE;
                        ctrl_ff <= 1'b0;
                        busy_ff <= 1'b1;
                        cnt_ff  <= step_up_i ? UP_CYC : DN_CYC;
                    end
                end
                HOST_PULSE: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (done) begin
                        st_ff   <= HOST_GAP;
                        ctrl_ff <= 1'b1;
                        cnt_ff  <= GAP_CYC;
                    end
                end
                HOST_GAP: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (done) begin
                        st_ff   <= HOST_HIGH;
                        busy_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign link.ctrl = ctrl_ff;
    assign busy_o    = busy_ff;
endmodule : ctrl_pin_host
`default_nettype wire

// ### bench/link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the control wire and the converter side of the link
module link_checker (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          ctrl,
    input  wire logic          uvlo_i,
    input  wire logic          overtemp_i,
    input  wire logic          fb_below_ref_i,
    input  wire logic          peak_reached_i,
    input  wire logic [3:0]    input_disconnect_switch_o,
    input  wire logic          main_power_switch_o,
    input  var link_pkg::lim_t switch_current_limit_o,
    input  wire logic [5:0]    dac_code_o,
    input  wire logic          enabled_o
);
    import link_pkg::*;
    logic [9:0] on_ff;
    logic [9:0] off_ff;
    logic [9:0] nxt_on;
    logic [9:0] nxt_off;
    // Switch run lengths; off count saturates so long idle never wraps
    assign nxt_on  = main_power_switch_o ? on_ff + 10'h001 : 10'h000;
    assign nxt_off = main_power_switch_o ? 10'h000 :
                     (&off_ff ? off_ff : off_ff + 10'h001);
    always_ff @(posedge clk_i) begin
        on_ff  <= sys_rst_i ? 10'h000 : nxt_on;
        off_ff <= sys_rst_i ? 10'h000 : nxt_off;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_off_safe;
        !enabled_o && $past(!enabled_o) |->
            input_disconnect_switch_o == 4'h0 && !main_power_switch_o;
    endproperty
    a_off_safe: assert property (p_off_safe)
        else $error("switches not open while off");
    property p_ramp;
        $changed(input_disconnect_switch_o) |-> input_disconnect_switch_o ==
            4'($past(input_disconnect_switch_o) + 4'h1) ||
            input_disconnect_switch_o == 4'h0;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("disconnect gate jumped");
    property p_fault;
        (uvlo_i || overtemp_i) [*6] |->
            input_disconnect_switch_o == 4'h0 && !main_power_switch_o;
    endproperty
    a_fault: assert property (p_fault)
        else $error("switches not open under fault");
    property p_max_on;
        main_power_switch_o |-> on_ff < 10'd600;
    endproperty
    a_max_on: assert property (p_max_on)
        else $error("main switch on too long");
    property p_min_off;
        $rose(main_power_switch_o) |-> off_ff >= 10'd40;
    endproperty
    a_min_off: assert property (p_min_off)
        else $error("main switch off time too short");
    property p_fb_gate;
        !fb_below_ref_i [*6] |-> !$rose(main_power_switch_o);
    endproperty
    a_fb_gate: assert property (p_fb_gate)
        else $error("main switch on without feedback low");
    property p_peak_off;
        peak_reached_i [*5] |-> !main_power_switch_o;
    endproperty
    a_peak_off: assert property (p_peak_off)
        else $error("main switch on past peak");
    property p_limit_seq;
        $changed(switch_current_limit_o) |->
            switch_current_limit_o == LIM_QUARTER ||
            $past(switch_current_limit_o) == switch_current_limit_o - 2'h1;
    endproperty
    a_limit_seq: assert property (p_limit_seq)
        else $error("current limit skipped a stage");
    property p_dac_step;
        $changed(dac_code_o) |-> dac_code_o == 6'h20 ||
            dac_code_o == 6'($past(dac_code_o) + 6'h01) ||
            dac_code_o == 6'($past(dac_code_o) - 6'h01);
    endproperty
    a_dac_step: assert property (p_dac_step)
        else $error("dac code moved by more than one");
    property p_gap;
        $rose(ctrl) |-> ctrl [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("control pin high gap too short");
endmodule : link_checker
`default_nettype wire

// ### bench/pulse_width_dac_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module pulse_width_dac_control_tb;
    import link_pkg::*;
    logic       clk_i, sys_rst_i, enable_i, step_up_i, step_down_i, busy_o;
    logic       uvlo_i, overtemp_i, fb_below_ref_i, peak_reached_i;
    logic       peak_auto, peak_lvl;
    logic       enabled_o, main_power_switch_o, prev_main, prev_ctrl;
    logic [3:0] input_disconnect_switch_o;
    logic [5:0] dac_code_o;
    lim_t       switch_current_limit_o;
    int         num_errors, samples_checked, falls, at_half, at_full;
    int         lo_run, last_lo, on_run, max_on, i;
    ctrl_link_if link ();
    // Step windows shrunk to keep the run short; shutdown stays full length
    ctrl_pin_host #(.UP_CYC(16'h0078), .DN_CYC(16'h00AA))
        i_ctrl_pin_host (.clk_i, .sys_rst_i,
        .link(link.host), .enable_i, .step_up_i, .step_down_i, .busy_o);
    pulse_width_dac_control #(.UP_MAX_CYC(16'h0096), .DN_MIN_CYC(16'h00A0),
        .DN_MAX_CYC(16'h00F0))
        i_pulse_width_dac_control (.clk_i, .sys_rst_i, .link(link.dev),
        .uvlo_i, .overtemp_i, .fb_below_ref_i, .peak_reached_i,
        .input_disconnect_switch_o, .main_power_switch_o,
        .switch_current_limit_o, .dac_code_o, .enabled_o);
    link_checker i_link_checker (.clk_i, .sys_rst_i, .ctrl(link.ctrl),
        .uvlo_i, .overtemp_i, .fb_below_ref_i, .peak_reached_i,
        .input_disconnect_switch_o, .main_power_switch_o,
        .switch_current_limit_o, .dac_code_o, .enabled_o);
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Peak flag trails the switch, so every on-time really shows on the pin
    // Count switch turn-offs per stage and measure pulse widths on the wire
    always @(negedge clk_i) begin
        peak_reached_i = peak_auto ? main_power_switch_o : peak_lvl;
        if (prev_main === 1'b1 && !main_power_switch_o) falls++;
        if (switch_current_limit_o == LIM_HALF && at_half == 0) at_half = falls;
        if (switch_current_limit_o == LIM_FULL && at_full == 0) at_full = falls;
        on_run = main_power_switch_o ? on_run + 1 : 0;
        if (on_run > max_on) max_on = on_run;
        if (link.ctrl && prev_ctrl === 1'b0) last_lo = lo_run;
        lo_run = link.ctrl ? 0 : lo_run + 1;
        prev_main = main_power_switch_o;
        prev_ctrl = link.ctrl;
        if (enabled_o !== 1'b1) begin
            falls = 0;
            at_half = 0;
            at_full = 0;
        end
    end
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cycles
    // Bounded wait for the disconnect gate to reach a level
    task automatic wait_gate(input logic [3:0] v);
        int n;
        for (n = 0; n < 5000 && input_disconnect_switch_o !== v; n++) cycles(1);
        if (n == 5000) begin
            `CHK("gate wait", v, input_disconnect_switch_o)
            print_verdict();
        end
    endtask : wait_gate
    // Request n host steps, then check the code and the last low width
    task automatic step(input logic up, input int n, input logic [5:0] exp,
                        input int width);
        int j;
        int k;
        for (j = 0; j < n; j++) begin
            step_up_i = up;
            step_down_i = !up;
            cycles(1);
            step_up_i = 1'b0;
            step_down_i = 1'b0;
            for (k = 0; k < 2000 && busy_o !== 1'b0; k++) cycles(1);
            if (k == 2000) begin
                `CHK("busy wait", 1'b0, busy_o)
                print_verdict();
            end
            cycles(2);
        end
        `CHK("dac code", exp, dac_code_o)
        `CHK("low width", width, last_lo)
    endtask : step
    initial begin
        sys_rst_i = 1'b1;
        {enable_i, step_up_i, step_down_i, uvlo_i, overtemp_i} = 5'h00;
        fb_below_ref_i = 1'b1;
        peak_auto = 1'b1;
        peak_lvl = 1'b0;
        cycles(16);
        sys_rst_i = 1'b0;
        cycles(2);
        `CHK("dac reset", 6'h20, dac_code_o)
        `CHK("gate reset", 4'h0, input_disconnect_switch_o)
        enable_i = 1'b1;
        cycles(250);
        `CHK("ramping", 1'b1, input_disconnect_switch_o < 4'hF)
        wait_gate(4'hF);
        `CHK("enabled", 1'b1, enabled_o)
        step(1'b1, 1, 6'h21, 120);
        step(1'b0, 2, 6'h1F, 170);
        step(1'b1, 33, 6'h3F, 120);
        step(1'b0, 64, 6'h00, 170);
        `CHK("half after", 256, at_half)
        `CHK("full after", 512, at_full)
        peak_auto = 1'b0;
        cycles(1000);
        `CHK("max on", 600, max_on)
        // Peak ends any on-time, then only feedback may hold the switch off
        peak_lvl = 1'b1;
        fb_below_ref_i = 1'b0;
        cycles(10);
        peak_lvl = 1'b0;
        cycles(50);
        `CHK("fb high main", 1'b0, main_power_switch_o)
        fb_below_ref_i = 1'b1;
        peak_auto = 1'b1;
        enable_i = 1'b0;
        cycles(56020);
        `CHK("shut down", 1'b0, enabled_o)
        `CHK("gate open", 4'h0, input_disconnect_switch_o)
        `CHK("main open", 1'b0, main_power_switch_o)
        enable_i = 1'b1;
        wait_gate(4'hF);
        `CHK("dac preset", 6'h20, dac_code_o)
        `CHK("limit restart", LIM_QUARTER, switch_current_limit_o)
        for (i = 0; i < 2; i++) begin
            uvlo_i = (i == 0);
            overtemp_i = (i == 1);
            cycles(10);
            `CHK("fault gate", 4'h0, input_disconnect_switch_o)
            `CHK("fault main", 1'b0, main_power_switch_o)
            uvlo_i = 1'b0;
            overtemp_i = 1'b0;
            wait_gate(4'hF);
        end
        print_verdict();
    end
endmodule : pulse_width_dac_control_tb
`default_nettype wire
